//--- common/tmr_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the timer block.
 * Assumes: included by bare name from the design modules and from the bench.
 */
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// Register offsets on the plain register port
`define TIMER_COUNT_OFS     2'h0
`define OPTION_CONFIG_OFS   2'h1
`define INTERRUPT_CTRL_OFS  2'h2

// Option field positions
`define OPT_PULLUP_BIT      7
`define OPT_INT_EDGE_BIT    6
`define OPT_SOURCE_BIT      5
`define OPT_EDGE_BIT        4
`define OPT_ASSIGN_BIT      3
`define OPT_RATE_HI         2
`define OPT_RATE_LO         0

// Interrupt control field positions
`define ICTL_ENABLE_BIT     5
`define ICTL_FLAG_BIT       2

// Reset values
`define OPTION_CONFIG_RST   8'hFF
`define TIMER_COUNT_RST     8'h00
`define INTERRUPT_CTRL_RST  8'h00

// Instruction cycles in which counting is held off after a count write
`define WRITE_HOLD_CYCLES   2'h2
// Internal phases per instruction cycle
`define PHASES_PER_CYCLE    4

`endif

//--- common/tmr_pkg.sv
/*
 * Types shared by the timer block.
 * Assumes: the defines header is available by bare name.
 */
package tmr_pkg;

  // Option register fields as software sees them
  typedef struct packed {
    logic       pullup_enable;
    logic       int_edge;
    logic       count_source_select;
    logic       source_edge_select;
    logic       prescaler_assignment;
    logic [2:0] prescale_rate;
  } option_t;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Phase sequencer states
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

endpackage : tmr_pkg

//--- rtl/phase_gen.sv
/*
 * Four-phase sequencer that splits the core clock into instruction cycles.
 * Assumes: one core clock; run low freezes the phases (sleep).
 */
`timescale 1ns/1ps
`include "tmr_defs.svh"

module phase_gen
  import tmr_pkg::*;
(
  input  wire logic core_clk,   // Core clock
  input  wire logic rstn,       // Synchronous reset, active low
  input  wire logic run,        // Phases advance while high
  output phase_t    phase,      // Current phase
  output logic      cycle_end   // Pulse on last phase of a cycle
);

  phase_t next_phase;

  // Step through Q1..Q4
  always_comb begin
    case (phase)
      PH_Q1:   next_phase = PH_Q2;
      PH_Q2:   next_phase = PH_Q3;
      PH_Q3:   next_phase = PH_Q4;
      PH_Q4:   next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  // Phase register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase <= PH_Q1;
    end else if (run) begin
      phase <= next_phase;
    end
  end

  assign cycle_end = run && (phase == PH_Q4);

endmodule : phase_gen

//--- rtl/shared_prescaler.sv
/*
 * Eight-bit prescaler shared between the timer and the watchdog.
 * Assumes: tick_in is a one-cycle enable; clear is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "tmr_defs.svh"

module shared_prescaler
  import tmr_pkg::*;
(
  input  wire logic       core_clk,  // Core clock
  input  wire logic       rstn,      // Synchronous reset, active low
  input  wire logic       tick_in,   // Input event to divide
  input  wire logic       clear,     // Reset the internal count
  input  wire logic [2:0] rate,      // Division select
  output logic            tick_out   // Divided event pulse
);

  logic [7:0] count;

  // Mask of low bits that must all be set before the carry leaves
  function automatic logic [7:0] rate_mask(input logic [2:0] r);
    rate_mask = 8'(({1'b0, 8'hFF} << (r + 4'h1)) >> 9'h0);
    rate_mask = ~rate_mask;
  endfunction : rate_mask

  // Output leaves when the selected low bits wrap
  assign tick_out = tick_in && ((count & rate_mask(rate)) == rate_mask(rate));

  // Internal count, never visible to software
  always_ff @(posedge core_clk) begin
    if (!rstn || clear) begin
      count <= 8'h00;
    end else if (tick_in) begin
      count <= count + 8'h01;
    end
  end

endmodule : shared_prescaler

//--- rtl/timer_counter.sv
/*
 * Eight-bit timer/counter with a prescaler shared with the watchdog.
 * Assumes: plain register port, read data one cycle after the read strobe;
 * the watchdog clear pulse and sleep level come from the core.
 */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tmr_defs.svh"

// What this block does
// - Single readable writable 8-bit count register
// - Source 0 counts each instruction cycle
// - Count held two cycles after write
// - Source 1 counts selected external input edges
// - External input sampled on Q2, Q4
// - Prescaler serves timer or watchdog, 0 timer
// - Rate field gives ratios 1:2 to 1:256
// - Undivided count only when prescaler to watchdog
// - Prescaler count hidden from software
// - Count write clears prescaler when timer-assigned
// - Watchdog clear clears prescaler when watchdog-assigned
// - Wrap FFh to 00h sets flag, interrupt
// - Flag set on every wrap regardless
// - Only software clears the overflow flag
// - Timer frozen during sleep
module timer_counter
  import tmr_pkg::*;
(
  input  wire logic       core_clk,             // Core clock, 100 MHz
  input  wire logic       rstn,                 // Synchronous reset, active low
  input  wire logic [1:0] addr,                 // Register address
  input  wire logic [7:0] wdata,                // Write data
  input  wire logic       wr,                   // Write strobe
  input  wire logic       rd,                   // Read strobe
  output logic      [7:0] rdata,                // Read data, cycle after rd
  input  wire logic       external_count_input, // External count pin
  input  wire logic       watchdog_clear,       // Watchdog clear instruction pulse
  input  wire logic       sleep,                // Core asleep
  input  wire logic       watchdog_tick,        // Watchdog base tick
  output logic            watchdog_step,        // Watchdog tick, scaled only when the watchdog owns the prescaler
  output logic            overflow_irq,         // Overflow interrupt request
  output logic            cycle_end             // Instruction cycle boundary
);

  option_t    option_config;
  logic [7:0] timer_count;
  logic       overflow_flag;
  logic       overflow_interrupt_enable;
  logic [1:0] hold_left;
  logic       ext_q2;
  logic       ext_q4;
  logic       ext_prev;
  logic       edge_seen;
  logic       src_tick;
  logic       to_timer;
  logic       psc_in;
  logic       psc_out;
  logic       psc_clear;
  logic       count_step;
  logic       inc;
  logic       wrap;
  logic       wr_count;
  logic       wr_ictl;
  phase_t     phase;

  // Address decode helper
  function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_count = wr && hit(addr, `TIMER_COUNT_OFS);
  assign wr_ictl  = wr && hit(addr, `INTERRUPT_CTRL_OFS);

  // Instruction cycle phases stop while asleep
  phase_gen u_phase (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .run       (!sleep),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // Option register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      option_config <= option_t'(`OPTION_CONFIG_RST);
    end else if (wr && hit(addr, `OPTION_CONFIG_OFS)) begin
      option_config <= option_t'(wdata);
    end
  end

  // External input sampled on Q2 and Q4 of each cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_q2 <= 1'b0;
      ext_q4 <= 1'b0;
    end else begin
      if (phase == PH_Q2 && !sleep) begin
        ext_q2 <= external_count_input;
      end
      if (phase == PH_Q4 && !sleep) begin
        ext_q4 <= ext_q2;
      end
    end
  end

  // Previous synchronised level for edge detect, updated per cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_prev <= 1'b0;
    end else if (cycle_end) begin
      ext_prev <= ext_q4;
    end
  end

  // Edge select: 1 counts falling, 0 counts rising
  assign edge_seen = option_config.source_edge_select ? (ext_prev && !ext_q4)
                                                       : (!ext_prev && ext_q4);

  // Source of count events, one per instruction cycle at most
  assign src_tick = cycle_end &&
                    (option_config.count_source_select ? edge_seen : 1'b1);

  // Prescaler routing: assignment 0 gives it to the timer
  assign to_timer  = !option_config.prescaler_assignment;
  assign psc_in    = to_timer ? src_tick : (watchdog_tick && !sleep);
  assign psc_clear = (to_timer && wr_count) ||
                     (!to_timer && watchdog_clear);

  shared_prescaler u_psc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick_in  (psc_in),
    .clear    (psc_clear),
    .rate     (option_config.prescale_rate),
    .tick_out (psc_out)
  );

  // Watchdog sees the prescaler only when it owns it
  assign watchdog_step = to_timer ? (watchdog_tick && !sleep) : psc_out;

  // Timer counts divided events, or undivided when watchdog owns prescaler
  assign count_step = to_timer ? psc_out : src_tick;
  assign inc        = count_step && (hold_left == 2'h0) && !sleep && !wr_count;
  assign wrap       = inc && (timer_count == 8'hFF);

  // Write hold-off counted in instruction cycles
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_left <= 2'h0;
    end else if (wr_count) begin
      hold_left <= `WRITE_HOLD_CYCLES;
    end else if (cycle_end && hold_left != 2'h0) begin
      hold_left <= hold_left - 2'h1;
    end
  end

  // Timer count register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      timer_count <= `TIMER_COUNT_RST;
    end else if (wr_count) begin
      timer_count <= wdata;
    end else if (inc) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // Overflow flag: set wins over a software clear, never self-clears
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_ictl) begin
      overflow_flag <= wdata[`ICTL_FLAG_BIT];
    end
  end

  // Interrupt enable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      overflow_interrupt_enable <= 1'b0;
    end else if (wr_ictl) begin
      overflow_interrupt_enable <= wdata[`ICTL_ENABLE_BIT];
    end
  end

  assign overflow_irq = overflow_flag && overflow_interrupt_enable;

  // Read data, prescaler count is not mapped
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `TIMER_COUNT_OFS:    rdata <= timer_count;
        `OPTION_CONFIG_OFS:  rdata <= option_config;
        `INTERRUPT_CTRL_OFS: rdata <= {2'h0, overflow_interrupt_enable, 2'h0,
                                       overflow_flag, 2'h0};
        default:             rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Count write takes effect on the next edge
  a_count_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_count |=> timer_count == $past(wdata))
    else $error("count write not stored");

  // Count unchanged on the seventh clock after a write
  a_write_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_count ##1 (!wr_count)[*7] |-> $stable(timer_count))
    else $error("count moved during write hold");

  // Wrap sets the flag
  a_wrap_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    wrap |=> overflow_flag && timer_count == 8'h00)
    else $error("wrap did not set flag");

  // Flag never drops without a software write
  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    overflow_flag && !wr_ictl |=> overflow_flag)
    else $error("flag cleared by hardware");

  // Enabled wrap raises the request on the next cycle
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    wrap && overflow_interrupt_enable && !wr_ictl |=> overflow_irq)
    else $error("interrupt not raised on wrap");

  // Frozen in sleep
  a_sleep_freeze: assert property (@(posedge core_clk) disable iff (!rstn)
    sleep && !wr_count |=> $stable(timer_count))
    else $error("timer moved in sleep");

  // Undivided timer mode steps once per cycle
  a_undivided: assert property (@(posedge core_clk) disable iff (!rstn)
    !to_timer && !option_config.count_source_select && cycle_end && hold_left == 2'h0
      && !sleep && !wr_count |=> timer_count == $past(timer_count) + 8'h01)
    else $error("undivided step missed");

  // Watchdog clear empties the prescaler when the watchdog owns it
  a_wdt_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    !to_timer && watchdog_clear |=> u_psc.count == 8'h00)
    else $error("watchdog clear left prescaler count");

  // Count write empties the prescaler when the timer owns it
  a_psc_write_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    to_timer && wr_count |=> u_psc.count == 8'h00)
    else $error("count write left prescaler count");

  // Count only moves on an instruction cycle boundary or a write
  a_cycle_only: assert property (@(posedge core_clk) disable iff (!rstn)
    !cycle_end && !wr_count |=> $stable(timer_count))
    else $error("count moved off a cycle boundary");

  // Counter mode needs a seen edge to step
  a_ext_edge: assert property (@(posedge core_clk) disable iff (!rstn)
    option_config.count_source_select && !edge_seen && !wr_count |=> $stable(timer_count))
    else $error("counter mode stepped without an edge");

  // Rising edge counted when edge select is 0
  a_rise_count: assert property (@(posedge core_clk) disable iff (!rstn)
    !to_timer && option_config.count_source_select && !option_config.source_edge_select
      && cycle_end && !ext_prev && ext_q4 && hold_left == 2'h0 && !wr_count
      |=> timer_count == $past(timer_count) + 8'h01)
    else $error("rising edge not counted");

  // Falling edge counted when edge select is 1
  a_fall_count: assert property (@(posedge core_clk) disable iff (!rstn)
    !to_timer && option_config.count_source_select && option_config.source_edge_select
      && cycle_end && ext_prev && !ext_q4 && hold_left == 2'h0 && !wr_count
      |=> timer_count == $past(timer_count) + 8'h01)
    else $error("falling edge not counted");

  // First sampling stage takes the pin on Q2
  a_sync_q2: assert property (@(posedge core_clk) disable iff (!rstn)
    phase == PH_Q2 && !sleep |=> ext_q2 == $past(external_count_input))
    else $error("pin not sampled on Q2");

  // First sampling stage holds outside Q2
  a_sync_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    phase != PH_Q2 |=> $stable(ext_q2))
    else $error("pin sampled outside Q2");

  // Second sampling stage moves on Q4
  a_sync_q4: assert property (@(posedge core_clk) disable iff (!rstn)
    phase == PH_Q4 && !sleep |=> ext_q4 == $past(ext_q2))
    else $error("second stage not loaded on Q4");

  // Prescaler owned by the timer only passes timer source events
  a_psc_owner: assert property (@(posedge core_clk) disable iff (!rstn)
    to_timer && !src_tick |-> !count_step)
    else $error("timer stepped from a foreign source");

  // Every timer ratio is at least 1:2
  a_rate_floor: assert property (@(posedge core_clk) disable iff (!rstn)
    to_timer && psc_out |-> u_psc.count[0])
    else $error("prescaler fired faster than 1:2");

  // Top rate fires only when all eight bits wrap
  a_rate_top: assert property (@(posedge core_clk) disable iff (!rstn)
    to_timer && psc_out && option_config.prescale_rate == 3'h7 |-> u_psc.count == 8'hFF)
    else $error("1:256 ratio broken");

  // Lowest rate fires on every second event
  a_rate_low: assert property (@(posedge core_clk) disable iff (!rstn)
    to_timer && src_tick && option_config.prescale_rate == 3'h0 && u_psc.count[0]
      |-> psc_out)
    else $error("1:2 ratio broken");

  // Read data is zero outside the answer cycle
  a_rd_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    !rd |=> rdata == 8'h00)
    else $error("read data outside answer cycle");

  // Unmapped address reads zero, prescaler never shows
  a_rd_unmapped: assert property (@(posedge core_clk) disable iff (!rstn)
    rd && addr == 2'h3 |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // Option write lands, assignment bit included
  a_opt_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr && addr == `OPTION_CONFIG_OFS |=> option_config == $past(wdata))
    else $error("option write not stored");

  // Software write of zero clears the flag
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_ictl && !wdata[`ICTL_FLAG_BIT] && !wrap |=> !overflow_flag)
    else $error("software clear of flag lost");

  // Wrap wins over a clear in the same cycle
  a_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
    wrap && wr_ictl |=> overflow_flag)
    else $error("wrap lost against clear");

  // No instruction cycle boundary while asleep
  a_sleep_phase: assert property (@(posedge core_clk) disable iff (!rstn)
    sleep |-> !cycle_end)
    else $error("cycle boundary during sleep");

  // Count read returns the count
  a_count_read: assert property (@(posedge core_clk) disable iff (!rstn)
    rd && addr == `TIMER_COUNT_OFS |=> rdata == $past(timer_count))
    else $error("count read wrong");

endmodule : timer_counter

//--- tb/tb_timer_counter.sv
/*
 * Self-checking bench for the eight-bit timer with shared prescaler.
 * Assumes: plain register port with read data one cycle after the strobe,
 * four core clocks per instruction cycle, cycle_end high on the last phase.
 */
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tb_timer_counter
  import tmr_pkg::*;
;
  logic       core_clk;              // Core clock
  logic       rstn;                  // Reset, active low
  logic [1:0] addr;                  // Register address
  logic [7:0] wdata;                 // Write data
  logic       wr;                    // Write strobe
  logic       rd;                    // Read strobe
  logic [7:0] rdata;                 // Read data
  logic       external_count_input;  // External count pin
  logic       watchdog_clear;        // Watchdog clear pulse
  logic       sleep;                 // Core asleep
  logic       watchdog_tick;         // Watchdog base tick
  logic       watchdog_step;         // Watchdog tick, scaled when watchdog-assigned
  logic       overflow_irq;          // Overflow request
  logic       cycle_end;             // Instruction cycle boundary
  int         errors;
  int         num_checks;
  int         steps;
  int         cycles;
  logic [7:0] c1;
  logic [7:0] c2;
  int         d;

  timer_counter DUT (
    .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .external_count_input(external_count_input),
    .watchdog_clear(watchdog_clear), .sleep(sleep), .watchdog_tick(watchdog_tick),
    .watchdog_step(watchdog_step), .overflow_irq(overflow_irq), .cycle_end(cycle_end)
  );

  // Clock generation
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Count scaled watchdog pulses where they are settled
  always @(negedge core_clk) begin
    if (watchdog_step === 1'b1) steps++;
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    v = rdata;
  endtask : rd_reg

  task automatic chk_rd(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    cmp(v, exp);
  endtask : chk_rd

  // Stop at the negedge before a counting edge
  task automatic sync_q4;
    @(negedge core_clk);
    while (cycle_end !== 1'b1) @(negedge core_clk);
  endtask : sync_q4

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      watchdog_tick <= 1'b1;
      @(posedge core_clk);
      watchdog_tick <= 1'b0;
    end
  endtask : tick

  task automatic wd_clear;
    @(posedge core_clk);
    watchdog_clear <= 1'b1;
    @(posedge core_clk);
    watchdog_clear <= 1'b0;
  endtask : wd_clear

  // Main sequence
  initial begin
    addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; rstn = 1'b0;
    external_count_input = 1'b0; watchdog_clear = 1'b0; sleep = 1'b0; watchdog_tick = 1'b0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    chk_rd(`OPTION_CONFIG_OFS, `OPTION_CONFIG_RST);
    chk_rd(`TIMER_COUNT_OFS, `TIMER_COUNT_RST);
    chk_rd(`INTERRUPT_CTRL_OFS, `INTERRUPT_CTRL_RST);
    wr_reg(2'h3, 8'hA5);
    chk_rd(2'h3, 8'h00);
    $display("test reset_values done");
    // Timer mode, prescaler on watchdog: count pauses two cycles after a write
    wr_reg(`OPTION_CONFIG_OFS, 8'h08);
    chk_rd(`OPTION_CONFIG_OFS, 8'h08);
    for (int m = 2; m < 6; m++) begin
      sync_q4();
      wr_reg(`TIMER_COUNT_OFS, 8'h40);
      repeat (4 * m - 1) @(posedge core_clk);
      chk_rd(`TIMER_COUNT_OFS, 8'(64 + m - 2));
    end
    $display("test write_hold done");
    // Every rate, then the undivided case, over an interval of two counts
    for (int r = 0; r < 9; r++) begin
      d = (r == 8) ? 1 : (2 << r);
      wd_clear();
      wr_reg(`OPTION_CONFIG_OFS, (r == 8) ? 8'h08 : {5'h00, 3'(r)});
      repeat (8 * d) @(posedge core_clk);
      rd_reg(`TIMER_COUNT_OFS, c1);
      repeat (8 * d - 2) @(posedge core_clk);
      rd_reg(`TIMER_COUNT_OFS, c2);
      cmp(c2 - c1, 8'h02);
    end
    $display("test prescale_rates done");
    // Repeated count writes keep a slow prescaler from ever firing
    wr_reg(`OPTION_CONFIG_OFS, 8'h07);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`TIMER_COUNT_OFS, 8'h05);
      repeat (196) @(posedge core_clk);
      chk_rd(`TIMER_COUNT_OFS, 8'h05);
    end
    $display("test write_clears_prescaler done");
    // Hand the prescaler to the watchdog in the safe order, then wrap
    wd_clear();
    wr_reg(`TIMER_COUNT_OFS, 8'h00);
    wr_reg(`OPTION_CONFIG_OFS, 8'h0F);
    wd_clear();
    wr_reg(`OPTION_CONFIG_OFS, 8'h08);
    wr_reg(`TIMER_COUNT_OFS, 8'hFE);
    repeat (40) @(posedge core_clk);
    chk_rd(`INTERRUPT_CTRL_OFS, 8'h04);
    cmp({7'h00, overflow_irq}, 8'h00);
    wr_reg(`INTERRUPT_CTRL_OFS, 8'h24);
    @(negedge core_clk);
    cmp({7'h00, overflow_irq}, 8'h01);
    repeat (100) @(posedge core_clk);
    chk_rd(`INTERRUPT_CTRL_OFS, 8'h24);
    wr_reg(`INTERRUPT_CTRL_OFS, 8'h20);
    chk_rd(`INTERRUPT_CTRL_OFS, 8'h20);
    cmp({7'h00, overflow_irq}, 8'h00);
    $display("test overflow done");
    // Sleep freezes the count
    @(posedge core_clk);
    sleep <= 1'b1;
    rd_reg(`TIMER_COUNT_OFS, c1);
    repeat (40) @(posedge core_clk);
    rd_reg(`TIMER_COUNT_OFS, c2);
    cmp(c2, c1);
    @(posedge core_clk);
    sleep <= 1'b0;
    $display("test sleep done");
    // Counter mode: rising edges, then falling edges
    for (int e = 0; e < 2; e++) begin
      wr_reg(`OPTION_CONFIG_OFS, (e == 1) ? 8'h38 : 8'h28);
      wr_reg(`TIMER_COUNT_OFS, 8'h00);
      repeat (12) @(posedge core_clk);
      repeat (3) begin
        external_count_input <= 1'b1;
        repeat (8) @(posedge core_clk);
        external_count_input <= 1'b0;
        repeat (8) @(posedge core_clk);
      end
      // Let the last edge pass both sampling stages
      repeat (12) @(posedge core_clk);
      chk_rd(`TIMER_COUNT_OFS, 8'h03);
    end
    $display("test counter_mode done");
    // Watchdog clear resets the prescaler when it serves the watchdog
    wr_reg(`OPTION_CONFIG_OFS, 8'h09);
    wd_clear();
    d = steps;
    repeat (4) begin
      tick(3);
      wd_clear();
    end
    cmp(8'(steps - d), 8'h00);
    tick(4);
    repeat (2) @(posedge core_clk);
    cmp(8'(steps - d), 8'h01);
    $display("test watchdog_clear done");
    close_out();
  end
endmodule : tb_timer_counter
